// ---- bench/reclk_link_model.sv ----
// Model of the equalised inputs and the recovery loop behind the selected channel
module reclk_link_model (
    input wire logic sys_clk_i,
    input wire logic [1:0] active_input_i,
    input wire logic [7:0] ch_rate_i,
    input wire logic [3:0] ch_data_i,
    input wire logic [3:0] ch_loop_i,
    input wire logic slow_i,
    output logic pll_locked_o,
    output logic data_valid_o,
    output logic [1:0] rate_detect_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] last_ch = 2'h0;
    logic [3:0] acq_cnt = 4'h0;
    logic data_now;
    logic [1:0] rate_now;
    initial begin
        pll_locked_o = 1'b0;
        data_valid_o = 1'b0;
        rate_detect_o = 2'h0;
    end
    assign data_now = ch_data_i[active_input_i];
    assign rate_now = data_now ? ch_rate_i[2*active_input_i+:2] : 2'h0;
    always @(posedge sys_clk_i) begin
        last_ch <= active_input_i;
        data_valid_o <= data_now;
        rate_detect_o <= rate_now;
        // Loop reacquires after every switch, slowly on request
        if (active_input_i != last_ch || !ch_loop_i[active_input_i] || rate_now == 2'h0) begin
            acq_cnt <= slow_i ? 4'hc : 4'h1;
            pll_locked_o <= 1'b0;
        end else if (acq_cnt != 4'h0) begin
            acq_cnt <= acq_cnt - 4'h1;
        end else begin
            pll_locked_o <= 1'b1;
        end
    end
endmodule // reclk_link_model

// ---- bench/tb_sdi_reclocker_control.sv ----
// Self-checking bench of the reclocker control block
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin mismatches++; \
    $display("BAD %0t got %h exp %h", $time, got, exp); end end
module tb_sdi_reclocker_control;
    timeunit 1ns;
    timeprecision 1ps;
    import reclk_pkg::*;
    localparam int SETTLE = 8;
    logic sys_clk_i = 1'b0, resetn_i = 1'b0;
    logic [3:0] s_axi_awaddr_i = 4'h0, s_axi_araddr_i = 4'h0, s_axi_wstrb_i = 4'hf;
    logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
    logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
    logic [31:0] s_axi_wdata_i = 32'h0000_0000, s_axi_rdata_o;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o, active_input_o;
    logic [1:0] rate_mode_i = 2'h0, chan_sel_i = 2'h0, rate_detect_i;
    logic bypass_i = 1'b0, mute_n_i = 1'b1, second_output_clock_select_i = 1'b0;
    logic enable_i = 1'b1, slow_i = 1'b0, pll_locked_i, data_valid_i;
    logic [7:0] strap_driven_i = 8'hff, ch_rate_i = 8'h01;
    logic [3:0] ch_data_i = 4'h1, ch_loop_i = 4'h1;
    logic lock_detect_o, rate_class_flag_o, retime_bypass_o, primary_output_mute_o;
    logic second_output_mute_o, second_output_clock_o, power_down_o, reference_osc_run_o;
    logic test_mode_o;
    logic [31:0] r;
    logic [8:0] obs;
    logic [8:0] want;
    int checks = 0, mismatches = 0, cyc = 0, n;

    sdi_reclocker_control #(.SETTLE_CYC(SETTLE)) i_dut (.*);
    reclk_link_model i_link (.sys_clk_i(sys_clk_i), .active_input_i(active_input_o),
        .ch_rate_i(ch_rate_i), .ch_data_i(ch_data_i), .ch_loop_i(ch_loop_i), .slow_i(slow_i),
        .pll_locked_o(pll_locked_i), .data_valid_o(data_valid_i), .rate_detect_o(rate_detect_i));

    always #10 sys_clk_i = ~sys_clk_i;
    assign obs = {lock_detect_o, rate_class_flag_o, retime_bypass_o, test_mode_o, power_down_o,
        primary_output_mute_o, second_output_mute_o, second_output_clock_o, reference_osc_run_o};

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [8:0] exp_out(logic [1:0] m, logic [1:0] d, logic pl, logic dv,
        logic b, logic mn, logic s, logic e);
        logic ok, lk;
        ok = (m == RATE_AUTO) ? d != DET_NONE : (m == RATE_SD) ? d == DET_SD :
             (m == RATE_HD) ? d[1] : 1'b0;
        lk = e & ~b & pl & dv & ok;
        return {lk, lk & (d == DET_SD), ~lk, m == RATE_TEST, ~e, ~mn | ~e,
                ~mn | ~e | (s & ~lk), s, 1'b1};
    endfunction

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge sys_clk_i);
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= d;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        s_axi_bready_i <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge sys_clk_i);
            if (!aw_done && s_axi_awready_o) begin
                aw_done = 1'b1;
                s_axi_awvalid_i <= 1'b0;
            end
            if (!w_done && s_axi_wready_o) begin
                w_done = 1'b1;
                s_axi_wvalid_i <= 1'b0;
            end
        end
        do @(posedge sys_clk_i); while (s_axi_bvalid_o !== 1'b1);
        `CHK(s_axi_bresp_o, er)
        s_axi_bready_i <= 1'b0;
    endtask

    task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge sys_clk_i);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i <= 1'b1;
        do @(posedge sys_clk_i); while (s_axi_arready_o !== 1'b1);
        s_axi_arvalid_i <= 1'b0;
        do @(posedge sys_clk_i); while (s_axi_rvalid_o !== 1'b1);
        `CHK({s_axi_rdata_o, s_axi_rresp_o}, {ed, er})
        s_axi_rready_i <= 1'b0;
    endtask

    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        r = $urandom(32'h5122_fa57);
        @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        `CHK({lock_detect_o, retime_bypass_o}, 2'b01)
        @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        repeat (20) @(posedge sys_clk_i);
        // Register map, unmapped places and software override
        axi_rd(CTRL_OFS, CTRL_RESET, RESP_OKAY);
        axi_rd(4'h8, 32'h0000_0000, RESP_SLVERR);
        axi_wr(4'hc, 32'hffff_ffff, RESP_SLVERR);
        axi_wr(STATUS_OFS, 32'hffff_ffff, RESP_OKAY);
        s_axi_wstrb_i <= 4'he;
        axi_wr(CTRL_OFS, 32'hffff_ff7f, RESP_OKAY);
        s_axi_wstrb_i <= 4'hf;
        axi_rd(CTRL_OFS, 32'h0000_0180, RESP_OKAY);
        axi_rd(STATUS_OFS, 32'h0000_0013, RESP_OKAY);
        axi_wr(CTRL_OFS, 32'h0000_01e1, RESP_OKAY);
        repeat (8) @(posedge sys_clk_i);
        axi_rd(STATUS_OFS, 32'h0000_0214, RESP_OKAY);
        axi_wr(CTRL_OFS, CTRL_RESET, RESP_OKAY);
        // Random pins and floating straps, every mode and rate code first
        for (int i = 0; i < 300; i++) begin
            r = $urandom;
            if (i < 16)
                r = {12'h000, 8'hff, 2'b11, i[3:2], 2'b00, 4'b1110, i[1:0]};
            @(posedge sys_clk_i);
            rate_mode_i <= r[1:0];
            bypass_i <= r[2];
            mute_n_i <= r[3];
            second_output_clock_select_i <= r[4];
            enable_i <= r[5];
            ch_rate_i[1:0] <= r[9:8];
            ch_data_i[0] <= r[10] | r[20];
            ch_loop_i[0] <= r[11] | r[21];
            strap_driven_i <= r[19:12];
            repeat (10) @(posedge sys_clk_i);
            @(negedge sys_clk_i);
            want = exp_out(r[1:0] & r[19:18], (r[10] | r[20]) ? r[9:8] : 2'h0, r[11] | r[21],
                r[10] | r[20], r[2] & r[15], r[3] | ~r[14], r[4] & r[13], r[5] | ~r[12]);
            `CHK(obs[8], want[8])
            `CHK(obs[7:6], want[7:6])
            `CHK(obs[5:4], want[5:4])
            `CHK(obs[3:0], want[3:0])
        end
        // Channel switching drops lock and holds it off
        @(posedge sys_clk_i);
        {rate_mode_i, bypass_i, mute_n_i, enable_i, strap_driven_i} <= {2'h0, 3'b011, 8'hff};
        {ch_rate_i, ch_data_i, ch_loop_i} <= {8'b01_10_11_01, 4'hf, 4'hf};
        repeat (12) @(posedge sys_clk_i);
        for (int k = 1; k < 5; k++) begin
            @(posedge sys_clk_i);
            chan_sel_i <= k[1:0];
            slow_i <= k[0];
            n = 0;
            do begin @(negedge sys_clk_i); n++; end while (active_input_o !== k[1:0] && n < 20);
            `CHK({active_input_o, lock_detect_o}, {k[1:0], 1'b0})
            n = 0;
            while (lock_detect_o !== 1'b1 && n < 60) begin
                @(negedge sys_clk_i);
                n++;
            end
            `CHK(n >= SETTLE, 1'b1)
            r[1:0] = ch_rate_i[2*k[1:0]+:2];
            `CHK({lock_detect_o, rate_class_flag_o}, {1'b1, r[1:0] == DET_SD})
        end
        stop_test();
    end
endmodule // tb_sdi_reclocker_control

// ---- inc/reclk_pkg.sv ----
// Shared constants and types of the reclocker control block
package reclk_pkg;

    // Rate mode pin codes
    localparam logic [1:0] RATE_AUTO = 2'h0;
    localparam logic [1:0] RATE_SD = 2'h1;
    localparam logic [1:0] RATE_HD = 2'h2;
    localparam logic [1:0] RATE_TEST = 2'h3;

    // Rate reported by the recovery loop
    localparam logic [1:0] DET_NONE = 2'h0;
    localparam logic [1:0] DET_SD = 2'h1;
    localparam logic [1:0] DET_HD = 2'h2;
    localparam logic [1:0] DET_3G = 2'h3;

    // Level seen on a strap pin that nothing drives
    localparam logic [1:0] PULL_RATE = 2'h0;
    localparam logic [1:0] PULL_CHAN = 2'h0;
    localparam logic PULL_BYPASS = 1'b0;
    localparam logic PULL_MUTE_N = 1'b1;
    localparam logic PULL_CLK_OUT = 1'b0;
    localparam logic PULL_ENABLE = 1'b1;

    // Register map, byte addresses
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h4;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0180;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int REF_PERIOD_NS = 37;
    localparam int FLAG_VALID_CYC = (REF_PERIOD_NS / CLK_PERIOD_NS < 1) ? 1 :
                                    REF_PERIOD_NS / CLK_PERIOD_NS;
    localparam int LOCK_DROP_MAX_NS = 1_000_000;
    localparam int LOCK_DROP_CYC = LOCK_DROP_MAX_NS / CLK_PERIOD_NS;

    typedef struct packed {
        logic [22:0] rsvd;
        logic enable;
        logic mute_n;
        logic clk_out_sel;
        logic bypass;
        logic [1:0] chan;
        logic [1:0] rate;
        logic sw_override;
    } ctrl_t;

    // Pin levels after pull resolution, before and after synchronising
    typedef struct packed {
        logic [1:0] rate;
        logic [1:0] chan;
        logic bypass;
        logic mute_n;
        logic clk_out_sel;
        logic enable;
        logic pll_locked;
        logic data_valid;
        logic [1:0] det;
    } pins_t;

endpackage

// ---- rtl/pin_sync.sv ----
// Two flip-flop synchroniser for a group of asynchronous levels
module pin_sync #(
    parameter int W = 1
) (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic [W-1:0] async_i,
    input wire logic [W-1:0] reset_val_i,
    output logic [W-1:0] sync_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_t;

    sync_t st;
    sync_t next_st;

    always_comb begin
        next_st.s1 = async_i;
        next_st.s2 = st.s1;
    end

    // Reset loads zero; the reader applies the mute and enable pull levels until the chain fills
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sync_o = st.s2;

    sync_chain_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        $past(resetn_i) && $past(resetn_i, 2) |-> sync_o == $past(async_i, 2))
        else $error("synchroniser output is not the input two cycles late");

    // Unused port kept for a uniform instance shape
    logic unused_reset_val;
    assign unused_reset_val = ^reset_val_i;
endmodule // pin_sync

// ---- rtl/sdi_reclocker_control.sv ----
// Control and indicator logic of a serial video reclocker with AXI4-Lite access
//
// Function
// - Rate pins pick auto, 270M or high rates
// - Undriven rate pins read low, auto detect
// - Rate code offers a separate test mode
// - Fixed 270M mode never locks on harmonics
// - Channel select routes one of four inputs
// - Undriven channel pins select input zero
// - Lock high only with data and locked loop
// - Forced bypass holds lock indicator low
// - Mute low silences both serial outputs
// - Mute overrides bypass and lock state
// - Undriven mute pin reads high, outputs on
// - Bypass high passes data without retiming
// - Bypass low: auto bypass when unlocked/unsupported
// - Undriven bypass pin reads low, auto bypass
// - Unmuted and unlocked outputs carry bypassed data
// - Rate flag high for 270M, else low
// - Rate flag registered, forced low when unlocked
// - Rate flag valid one reference period after lock
// - Input change drops lock within 1 ms
// - Second output carries clock or data copy
// - Disable powers down, oscillator keeps running
// - Enable active high, reads high when undriven
// - Clock-mode second output muted during bypass
// - Unsupported rates never lock, enter bypass
//
// Added by the designer: the AXI4-Lite register port and the register offsets.
module sdi_reclocker_control
    import reclk_pkg::*;
#(
    parameter int SETTLE_CYC = reclk_pkg::LOCK_DROP_CYC
) (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    // AXI4-Lite slave
    input wire logic [reclk_pkg::ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [reclk_pkg::ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // Strap pins and pad-drive indications
    input wire logic [1:0] rate_mode_i,
    input wire logic [1:0] chan_sel_i,
    input wire logic bypass_i,
    input wire logic mute_n_i,
    input wire logic second_output_clock_select_i,
    input wire logic enable_i,
    input wire logic [7:0] strap_driven_i,
    // Status from the recovery loop
    input wire logic pll_locked_i,
    input wire logic data_valid_i,
    input wire logic [1:0] rate_detect_i,
    // Indicators and data path controls
    output logic lock_detect_o,
    output logic rate_class_flag_o,
    output logic [1:0] active_input_o,
    output logic retime_bypass_o,
    output logic primary_output_mute_o,
    output logic second_output_mute_o,
    output logic second_output_clock_o,
    output logic power_down_o,
    output logic reference_osc_run_o,
    output logic test_mode_o
);
    import reclk_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Pin resolution and synchronisers

    pins_t pin_raw;
    pins_t pin_q;
    pins_t pin_reset;

    always_comb begin
        pin_raw.rate[1] = strap_driven_i[7] ? rate_mode_i[1] : PULL_RATE[1];
        pin_raw.rate[0] = strap_driven_i[6] ? rate_mode_i[0] : PULL_RATE[0];
        pin_raw.chan[1] = strap_driven_i[5] ? chan_sel_i[1] : PULL_CHAN[1];
        pin_raw.chan[0] = strap_driven_i[4] ? chan_sel_i[0] : PULL_CHAN[0];
        pin_raw.bypass = strap_driven_i[3] ? bypass_i : PULL_BYPASS;
        pin_raw.mute_n = strap_driven_i[2] ? mute_n_i : PULL_MUTE_N;
        pin_raw.clk_out_sel = strap_driven_i[1] ? second_output_clock_select_i : PULL_CLK_OUT;
        pin_raw.enable = strap_driven_i[0] ? enable_i : PULL_ENABLE;
        pin_raw.pll_locked = pll_locked_i;
        pin_raw.data_valid = data_valid_i;
        pin_raw.det = rate_detect_i;
        pin_reset = '0;
    end

    pin_sync #(
        .W($bits(pins_t))
    ) u_pin_sync (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .async_i(pin_raw),
        .reset_val_i(pin_reset),
        .sync_o(pin_q)
    );

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        ctrl_t ctrl;
        logic [1:0] fill;
        logic aw_held;
        logic [ADDR_W-1:0] aw_addr;
        logic w_held;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic lock;
        logic rate_flag;
        logic [1:0] active_chan;
        logic bypass;
        logic pmute;
        logic smute;
        logic clk_out;
        logic pdown;
        logic osc_run;
        logic test;
        logic [15:0] settle;
    } state_t;

    state_t st;
    state_t next_st;

    // Effective controls: pins, or the register copy under software override
    logic [1:0] eff_rate;
    logic [1:0] eff_chan;
    logic eff_bypass;
    logic eff_mute_n;
    logic eff_clk_out;
    logic eff_enable;
    logic supported;
    logic [31:0] status_word;

    always_comb begin
        eff_rate = st.ctrl.sw_override ? st.ctrl.rate : pin_q.rate;
        eff_chan = st.ctrl.sw_override ? st.ctrl.chan : pin_q.chan;
        eff_bypass = st.ctrl.sw_override ? st.ctrl.bypass : pin_q.bypass;
        eff_mute_n = st.ctrl.sw_override ? st.ctrl.mute_n : pin_q.mute_n;
        eff_clk_out = st.ctrl.sw_override ? st.ctrl.clk_out_sel : pin_q.clk_out_sel;
        eff_enable = st.ctrl.sw_override ? st.ctrl.enable : pin_q.enable;
        // Until the synchronisers fill, pull levels stand in for the mute and enable pins
        if (st.fill != 2'h3) begin
            eff_mute_n = PULL_MUTE_N;
            eff_enable = PULL_ENABLE;
        end
    end

    always_comb begin
        case (eff_rate)
            RATE_AUTO: supported = (pin_q.det != DET_NONE);
            RATE_SD: supported = (pin_q.det == DET_SD);
            RATE_HD: supported = (pin_q.det == DET_HD) || (pin_q.det == DET_3G);
            default: supported = 1'b0;
        endcase
    end

    always_comb begin
        status_word = '0;
        status_word[0] = st.lock;
        status_word[1] = st.rate_flag;
        status_word[2] = st.bypass;
        status_word[3] = st.test;
        status_word[5:4] = pin_q.det;
        status_word[7:6] = st.active_chan;
        status_word[8] = st.pdown;
        status_word[9] = st.smute;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        next_st = st;
        next_st.fill = (st.fill == 2'h3) ? st.fill : st.fill + 2'h1;

        // AXI4-Lite write: address and data taken in either order
        if (s_axi_awvalid_i && st.awready) begin
            next_st.aw_held = 1'b1;
            next_st.aw_addr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && st.wready) begin
            next_st.w_held = 1'b1;
            next_st.wdata = s_axi_wdata_i;
            next_st.wstrb = s_axi_wstrb_i;
        end
        if (st.bvalid && s_axi_bready_i) begin
            next_st.bvalid = 1'b0;
        end
        if (st.aw_held && st.w_held && !st.bvalid) begin
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = RESP_OKAY;
            if (st.aw_addr == CTRL_OFS) begin
                for (int b = 0; b < 4; b++) begin
                    if (st.wstrb[b]) begin
                        next_st.ctrl[b*8 +: 8] = st.wdata[b*8 +: 8];
                    end
                end
                next_st.ctrl.rsvd = '0;
            end else if (st.aw_addr == STATUS_OFS) begin
                next_st.bresp = RESP_OKAY;
            end else begin
                next_st.bresp = RESP_SLVERR;
            end
        end
        next_st.awready = !next_st.aw_held && !next_st.bvalid;
        next_st.wready = !next_st.w_held && !next_st.bvalid;

        // AXI4-Lite read
        if (st.rvalid && s_axi_rready_i) begin
            next_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid_i && st.arready) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = RESP_OKAY;
            if (s_axi_araddr_i == CTRL_OFS) begin
                next_st.rdata = st.ctrl;
            end else if (s_axi_araddr_i == STATUS_OFS) begin
                next_st.rdata = status_word;
            end else begin
                next_st.rdata = '0;
                next_st.rresp = RESP_SLVERR;
            end
        end
        next_st.arready = !next_st.rvalid;

        next_st.active_chan = eff_chan;

        // input change drops lock and holds it off
        if (eff_chan != st.active_chan) begin
            next_st.settle = 16'(SETTLE_CYC);
        end else if (st.settle != 16'h0000) begin
            next_st.settle = st.settle - 16'h0001;
        end

        // lock needs data, loop lock, no forced bypass
        next_st.lock = eff_enable && !eff_bypass && pin_q.pll_locked && pin_q.data_valid &&
                       supported && (eff_chan == st.active_chan) &&
                       (st.settle == 16'h0000) && (st.fill == 2'h3);

        next_st.bypass = eff_bypass || !next_st.lock;

        next_st.rate_flag = next_st.lock && (pin_q.det == DET_SD);

        next_st.pmute = !eff_mute_n || !eff_enable;

        next_st.clk_out = eff_clk_out;
        next_st.smute = next_st.pmute || (eff_clk_out && next_st.bypass);

        next_st.pdown = !eff_enable;
        next_st.osc_run = 1'b1;

        next_st.test = (eff_rate == RATE_TEST);
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            st <= '0;
            st.ctrl <= CTRL_RESET;
            st.bypass <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign s_axi_awready_o = st.awready;
    assign s_axi_wready_o = st.wready;
    assign s_axi_bresp_o = st.bresp;
    assign s_axi_bvalid_o = st.bvalid;
    assign s_axi_arready_o = st.arready;
    assign s_axi_rdata_o = st.rdata;
    assign s_axi_rresp_o = st.rresp;
    assign s_axi_rvalid_o = st.rvalid;
    assign lock_detect_o = st.lock;
    assign rate_class_flag_o = st.rate_flag;
    assign active_input_o = st.active_chan;
    assign retime_bypass_o = st.bypass;
    assign primary_output_mute_o = st.pmute;
    assign second_output_mute_o = st.smute;
    assign second_output_clock_o = st.clk_out;
    assign power_down_o = st.pdown;
    assign reference_osc_run_o = st.osc_run;
    assign test_mode_o = st.test;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!resetn_i);

    lock_when_bypass_a: assert property (
        $past(eff_bypass) |-> !lock_detect_o)
        else $error("lock indicator high under forced bypass");

    mute_priority_a: assert property (
        $past(!eff_mute_n) |-> primary_output_mute_o && second_output_mute_o)
        else $error("outputs not muted while mute is low");

    flag_unlocked_a: assert property (
        !lock_detect_o |-> !rate_class_flag_o)
        else $error("rate flag high while unlocked");

    flag_value_a: assert property (
        lock_detect_o |-> rate_class_flag_o == ($past(pin_q.det) == DET_SD))
        else $error("rate flag does not match the locked rate");

    flag_follow_a: assert property (
        $changed(lock_detect_o) |-> ##[0:1] (rate_class_flag_o ==
        (lock_detect_o && ($past(pin_q.det) == DET_SD))))
        else $error("rate flag late after lock change");

    chan_drop_a: assert property (
        $past(eff_chan) != $past(st.active_chan) |-> !lock_detect_o [*2])
        else $error("lock held across an input change");

    auto_bypass_a: assert property (
        !lock_detect_o |-> retime_bypass_o)
        else $error("retiming active while unlocked");

    clk_bypass_mute_a: assert property (
        second_output_clock_o && retime_bypass_o |-> second_output_mute_o)
        else $error("clock output not muted in bypass");

    test_no_lock_a: assert property (
        $past(eff_rate) == RATE_TEST |-> test_mode_o && !lock_detect_o)
        else $error("test code used as a rate mode");

    sd_no_harmonic_a: assert property (
        $past(eff_rate) == RATE_SD && $past(pin_q.det) != DET_SD |-> !lock_detect_o)
        else $error("fixed 270M mode locked to another rate");

    power_osc_a: assert property (
        $past(!eff_enable) |-> power_down_o && reference_osc_run_o && !lock_detect_o)
        else $error("disable did not power down or stopped the oscillator");

    axi_resp_a: assert property (
        s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
        else $error("write response dropped before it was taken");
endmodule // sdi_reclocker_control
